//--- rtcawf_pkg.sv
/*
  Shared types and constants of the alarm, watchdog and flag block.
  Assumes a 100 MHz system clock and a 1/16 second timekeeping tick.
*/
package rtcawf_pkg;

  // Calendar fields compared by the alarms
  typedef struct packed {
    logic [7:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcawf_date_t;

  // Status flags as seen by a flag read
  typedef struct packed {
    logic watchdog_timeout_flag;
    logic alarm_one_match_flag;
    logic alarm_two_match_flag;
    logic oscillator_fail_flag;
  } rtcawf_flags_t;

  // Watchdog register: resolution code and multiplier
  typedef struct packed {
    logic [1:0] resolution;
    logic [4:0] multiplier;
  } rtcawf_wdg_t;

  // Field limits
  localparam logic [3:0] SUB_MAX  = 4'hF;
  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [5:0] MIN_MAX  = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [7:0] DAY_MAX  = 8'hFF;

  // Tick timing: one sub-second step every 62.5 ms
  localparam int TICK_PERIOD_NS = 62_500_000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Watchdog count width in ticks (64 x 31 fits)
  localparam int WDG_CNT_W = 12;

  // Resolution factors in ticks: 1/16 s, 1/4 s, 1 s, 4 s
  localparam logic [6:0] RES_F0 = 7'h01;
  localparam logic [6:0] RES_F1 = 7'h04;
  localparam logic [6:0] RES_F2 = 7'h10;
  localparam logic [6:0] RES_F3 = 7'h40;

  // Reset values
  localparam logic          HALT_RST  = 1'b1;
  localparam rtcawf_flags_t FLAGS_RST = 4'h0;
  localparam rtcawf_date_t  DATE_RST  = 25'h0000000;

endpackage

//--- rtcawf_top.sv
/*
  Alarm, watchdog, halt and status-flag logic of a real-time clock.
  Assumes all inputs are synchronous to CLK_SYS and that access
  strobes are one-cycle pulses from the host's serial register port.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Alarm one match sets its flag
// - Alarm one enable drives first interrupt line
// - Alarm two works only when enabled
// - Alarm two enable drives second interrupt line
// - Alarm two match sets its flag
// - Flag read clears set alarm flags
// - Watchdog period is resolution times multiplier
// - Unserviced watchdog period raises timeout flag
// - Watchdog interrupt holds until watchdog write
// - Writing zero disables the watchdog
// - Oscillator flag holds until host clears it
// - Time stands still while halt set
// - Sub-second field readable beside seconds
// - Power-down sets the halt bit
// - Alarm and timeout flags cleared only by flag read
module rtcawf_top
  import rtcawf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic          CLK_SYS,
  input  wire logic          RST_N,
  // Time setting and readback
  input  wire logic          TIME_WR,
  input  wire rtcawf_date_t  TIME_WDATA,
  output rtcawf_date_t       TIME_NOW,
  output logic [3:0]         TIME_SUB,
  // Alarms
  input  wire logic          ALM1_WR,
  input  wire rtcawf_date_t  ALM1_WDATA,
  input  wire logic          ALM2_WR,
  input  wire rtcawf_date_t  ALM2_WDATA,
  input  wire logic          ALARM_ONE_IRQ_ENABLE,
  input  wire logic          ALARM_TWO_ENABLE,
  input  wire logic          ALARM_TWO_IRQ_ENABLE,
  // Watchdog
  input  wire logic          WDG_WR,
  input  wire rtcawf_wdg_t   WDG_WDATA,
  // Flags
  input  wire logic          FLAG_RD,
  output rtcawf_flags_t      FLAG_RDATA,
  input  wire logic          OSC_FAIL_IN,
  input  wire logic          OSC_FLAG_CLR,
  // Halt
  input  wire logic          POWER_DOWN,
  input  wire logic          HALT_WR,
  input  wire logic          HALT_WDATA,
  output logic               CLOCK_HALT_BIT,
  // Interrupt lines
  output logic               INTERRUPT_LINE_ONE_N,
  output logic               INTERRUPT_LINE_TWO_N
);

  localparam int DIV_W = $clog2(TICK_CYCLES);

  // Wrapping increment of a counter field
  function automatic logic [7:0] wrap_inc(input logic [7:0] v,
                                          input logic [7:0] lim);
    wrap_inc = (v == lim) ? 8'h00 : v + 8'h01;
  endfunction

  // Watchdog period in ticks
  function automatic logic [WDG_CNT_W-1:0] wdg_period(
    input rtcawf_wdg_t w);
    logic [6:0] f;
    unique case (w.resolution)
      2'h0: f = RES_F0;
      2'h1: f = RES_F1;
      2'h2: f = RES_F2;
      2'h3: f = RES_F3;
    endcase
    // Widen both factors first: 64 x 31 does not fit in seven bits
    wdg_period = WDG_CNT_W'(f) * WDG_CNT_W'(w.multiplier);
  endfunction

  // Timekeeping state
  logic [DIV_W-1:0] div_q,   div_d;    // Tick divider
  logic             tick_q,  tick_d;   // 1/16 s enable
  logic [3:0]       sub_q,   sub_d;    // Sub-second count
  rtcawf_date_t     time_q,  time_d;   // Calendar time
  logic             step_q,  step_d;   // New second reached
  logic             halt_q,  halt_d;   // Clock-halt bit
  rtcawf_date_t     alm1_q,  alm1_d;   // Alarm one setting
  rtcawf_date_t     alm2_q,  alm2_d;   // Alarm two setting
  // Watchdog state
  logic [WDG_CNT_W-1:0] wcnt_q, wcnt_d; // Remaining ticks
  logic             wrun_q,  wrun_d;   // Watchdog running
  logic             wirq_q,  wirq_d;   // Timeout holds line one
  // Flag state
  rtcawf_flags_t    flags_q, flags_d;  // Status flags
  rtcawf_flags_t    rdat_q,  rdat_d;   // Flag read data
  logic             interrupt_line_one_n_n_q, interrupt_line_one_n_n_d; // Line one level, low active
  logic             interrupt_line_two_n_n_q, interrupt_line_two_n_n_d; // Line two level, low active

  logic a1_hit;   // Alarm one match this cycle
  logic a2_hit;   // Alarm two match this cycle
  logic w_expire; // Watchdog period ran out

  assign a1_hit   = step_q && (time_q == alm1_q);
  assign a2_hit   = step_q && (time_q == alm2_q) && ALARM_TWO_ENABLE;
  assign w_expire = wrun_q && tick_q && (wcnt_q == WDG_CNT_W'(1));

  // Divider, time counting, halt and alarm settings
  always_comb begin
    div_d  = div_q;
    tick_d = 1'b0;
    sub_d  = sub_q;
    time_d = time_q;
    step_d = 1'b0;
    halt_d = halt_q;
    alm1_d = ALM1_WR ? ALM1_WDATA : alm1_q;
    alm2_d = ALM2_WR ? ALM2_WDATA : alm2_q;
    if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + DIV_W'(1);
    end
    // Halt bit: power-down set wins over a host clear
    if (HALT_WR) begin
      halt_d = HALT_WDATA;
    end
    if (POWER_DOWN) begin
      halt_d = 1'b1;
    end
    if (TIME_WR) begin
      time_d = TIME_WDATA;
      sub_d  = 4'h0;
    end else if (tick_q && !halt_q) begin
      sub_d = 4'(wrap_inc({4'h0, sub_q}, {4'h0, SUB_MAX}));
      if (sub_q == SUB_MAX) begin
        step_d = 1'b1;
        time_d.second = 6'(wrap_inc({2'h0, time_q.second},
                                    {2'h0, SEC_MAX}));
        if (time_q.second == SEC_MAX) begin
          time_d.minute = 6'(wrap_inc({2'h0, time_q.minute},
                                      {2'h0, MIN_MAX}));
          if (time_q.minute == MIN_MAX) begin
            time_d.hour = 5'(wrap_inc({3'h0, time_q.hour},
                                      {3'h0, HOUR_MAX}));
            if (time_q.hour == HOUR_MAX) begin
              time_d.day = wrap_inc(time_q.day, DAY_MAX);
            end
          end
        end
      end
    end
  end

  // Timekeeping registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      div_q  <= '0;
      tick_q <= 1'b0;
      sub_q  <= 4'h0;
      time_q <= DATE_RST;
      step_q <= 1'b0;
      halt_q <= HALT_RST;
      alm1_q <= DATE_RST;
      alm2_q <= DATE_RST;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
      sub_q  <= sub_d;
      time_q <= time_d;
      step_q <= step_d;
      halt_q <= halt_d;
      alm1_q <= alm1_d;
      alm2_q <= alm2_d;
    end
  end

  // Watchdog: load on write, count ticks, stop at timeout
  always_comb begin
    wcnt_d = wcnt_q;
    wrun_d = wrun_q;
    wirq_d = wirq_q;
    if (WDG_WR) begin
      wcnt_d = wdg_period(WDG_WDATA);
      wrun_d = (wdg_period(WDG_WDATA) != '0);
      wirq_d = 1'b0;
    end else if (w_expire) begin
      wrun_d = 1'b0;
      wirq_d = 1'b1;
    end else if (wrun_q && tick_q) begin
      wcnt_d = wcnt_q - WDG_CNT_W'(1);
    end
  end

  // Watchdog registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wcnt_q <= '0;
      wrun_q <= 1'b0;
      wirq_q <= 1'b0;
    end else begin
      wcnt_q <= wcnt_d;
      wrun_q <= wrun_d;
      wirq_q <= wirq_d;
    end
  end

  // Flags: read clears alarm and timeout flags, a new event wins
  always_comb begin
    flags_d = flags_q;
    rdat_d  = rdat_q;
    if (FLAG_RD) begin
      rdat_d = flags_q;
      flags_d.alarm_one_match_flag  = 1'b0;
      flags_d.alarm_two_match_flag  = 1'b0;
      flags_d.watchdog_timeout_flag = 1'b0;
    end
    if (OSC_FLAG_CLR) begin
      flags_d.oscillator_fail_flag = 1'b0;
    end
    if (OSC_FAIL_IN) begin
      flags_d.oscillator_fail_flag = 1'b1;
    end
    if (a1_hit) begin
      flags_d.alarm_one_match_flag = 1'b1;
    end
    if (a2_hit) begin
      flags_d.alarm_two_match_flag = 1'b1;
    end
    if (w_expire) begin
      flags_d.watchdog_timeout_flag = 1'b1;
    end
    // Lines are kept low-active in their flops so pins need no gate
    interrupt_line_one_n_n_d = !((flags_q.alarm_one_match_flag && ALARM_ONE_IRQ_ENABLE)
                 || wirq_q);
    interrupt_line_two_n_n_d = !(flags_q.alarm_two_match_flag
                 && ALARM_TWO_IRQ_ENABLE);
  end

  // Flag and interrupt registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flags_q <= FLAGS_RST;
      rdat_q  <= FLAGS_RST;
      interrupt_line_one_n_n_q <= 1'b1;
      interrupt_line_two_n_n_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      rdat_q  <= rdat_d;
      interrupt_line_one_n_n_q <= interrupt_line_one_n_n_d;
      interrupt_line_two_n_n_q <= interrupt_line_two_n_n_d;
    end
  end

  // Outputs straight from flip-flops
  assign TIME_NOW             = time_q;
  assign TIME_SUB             = sub_q;
  assign FLAG_RDATA           = rdat_q;
  assign CLOCK_HALT_BIT       = halt_q;
  assign INTERRUPT_LINE_ONE_N = interrupt_line_one_n_n_q;
  assign INTERRUPT_LINE_TWO_N = interrupt_line_two_n_n_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_wdg_fire;
    w_expire ##1 !WDG_WR;
  endsequence

  sequence s_a1_seen;
    flags_q.alarm_one_match_flag && ALARM_ONE_IRQ_ENABLE;
  endsequence

  a_alarm_one_set: assert property (
    a1_hit |=> flags_q.alarm_one_match_flag)
    else $error("alarm one match did not set flag");
  a_alarm_one_line: assert property (
    s_a1_seen |=> !INTERRUPT_LINE_ONE_N)
    else $error("line one not asserted for alarm one");
  a_alarm_two_gate: assert property (
    !ALARM_TWO_ENABLE && !flags_q.alarm_two_match_flag
    |=> !flags_q.alarm_two_match_flag)
    else $error("alarm two flag set while disabled");
  a_alarm_two_line: assert property (
    flags_q.alarm_two_match_flag && ALARM_TWO_IRQ_ENABLE
    |=> !INTERRUPT_LINE_TWO_N)
    else $error("line two not asserted for alarm two");
  a_alarm_two_set: assert property (
    a2_hit |=> flags_q.alarm_two_match_flag)
    else $error("alarm two match did not set flag");
  a_read_clears: assert property (
    FLAG_RD && !a1_hit |=> !flags_q.alarm_one_match_flag
    && FLAG_RDATA == $past(flags_q))
    else $error("flag read did not clear or return flags");
  a_wdg_period: assert property (
    WDG_WR |=> wcnt_q == wdg_period($past(WDG_WDATA)))
    else $error("watchdog period not loaded");
  a_wdg_timeout: assert property (
    w_expire |=> flags_q.watchdog_timeout_flag)
    else $error("watchdog expiry did not set flag");
  a_wdg_line_hold: assert property (
    s_wdg_fire |=> !INTERRUPT_LINE_ONE_N)
    else $error("line one released before watchdog write");
  a_wdg_zero_off: assert property (
    WDG_WR && wdg_period(WDG_WDATA) == '0 |=> !wrun_q[*2])
    else $error("zero watchdog write did not disable");
  a_osc_flag_hold: assert property (
    flags_q.oscillator_fail_flag && !OSC_FLAG_CLR
    |=> flags_q.oscillator_fail_flag)
    else $error("oscillator flag lost without clear");
  a_halt_freeze: assert property (
    halt_q && !TIME_WR |=> $stable(time_q) && $stable(sub_q))
    else $error("time advanced while halted");
  a_sub_advance: assert property (
    tick_q && !halt_q && !TIME_WR
    |=> sub_q == 4'($past(sub_q) + 4'h1))
    else $error("sub-second field did not advance");
  a_power_halt: assert property (
    POWER_DOWN |=> CLOCK_HALT_BIT)
    else $error("power-down did not set halt");
  a_flag_keep: assert property (
    !FLAG_RD && flags_q.alarm_one_match_flag
    |=> flags_q.alarm_one_match_flag)
    else $error("alarm flag cleared without a read");

endmodule

//--- rtcawf_host.sv
/*
  Host model: drives the block's access strobes and level controls.
  Assumes strobes change at the falling edge of the system clock.
*/
`timescale 1ns/1ps

module rtcawf_host
  import rtcawf_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Access strobes and their data
  output logic          time_wr,
  output rtcawf_date_t  time_wdata,
  output logic          alm1_wr,
  output rtcawf_date_t  alm1_wdata,
  output logic          alm2_wr,
  output rtcawf_date_t  alm2_wdata,
  output logic          wdg_wr,
  output rtcawf_wdg_t   wdg_wdata,
  output logic          flag_rd,
  input  wire rtcawf_flags_t flag_rdata,
  // Level controls and events
  output logic [2:0]    ens,
  output logic          osc_fail,
  output logic          osc_clr,
  output logic          pwr_dn,
  output logic          halt_wr,
  output logic          halt_wdata
);
  logic [8:0] stb = 9'h000; // One bit per strobe kind

  // Each strobe is one cycle wide and addresses one register
  assign {halt_wr, pwr_dn, osc_clr, osc_fail,
          flag_rd} = stb[8:4];
  assign {wdg_wr, alm2_wr, alm1_wr, time_wr} = stb[3:0];

  initial begin
    {time_wdata, alm1_wdata, alm2_wdata} = '0;
    {wdg_wdata, ens, halt_wdata} = '0;
  end

  // Raise one strobe for a single cycle
  task automatic go(input int k);
    stb[k] = 1'b1;
    @(negedge clk);
    stb = 9'h000;
  endtask

  task automatic pulse(input int k);
    @(negedge clk);
    go(k);
  endtask

  task automatic wr_time(input rtcawf_date_t d);
    @(negedge clk);
    time_wdata = d;
    go(0);
  endtask

  task automatic wr_alm(input int n, input rtcawf_date_t d);
    @(negedge clk);
    if (n == 1) alm1_wdata = d;
    else alm2_wdata = d;
    go(n);
  endtask

  task automatic wr_wdg(input rtcawf_wdg_t w);
    @(negedge clk);
    wdg_wdata = w;
    go(3);
  endtask

  task automatic wr_halt(input logic b);
    @(negedge clk);
    halt_wdata = b;
    go(8);
  endtask

  // Enables: alarm one irq, alarm two, alarm two irq
  task automatic en(input logic [2:0] b);
    @(negedge clk);
    ens = b;
  endtask

  // Flag read: answer stands from the cycle after the strobe
  task automatic rd_flags(output rtcawf_flags_t f);
    @(negedge clk);
    go(4);
    @(negedge clk);
    f = flag_rdata;
  endtask
endmodule

//--- tb_rtcawf_top.sv
/*
  Testbench of the alarm, watchdog and flag block.
  Assumes the host model drives every access input.
*/
`timescale 1ns/1ps

module tb_rtcawf_top
  import rtcawf_pkg::*;
();
  localparam int TK = 8; // Short tick for simulation
  logic clk = 1'b0, rst_n = 1'b0;
  logic tw, a1w, a2w, ww, frd, of, oc, pd, hw, hd, halt, l1_n, l2_n;
  logic [2:0] ens;
  logic [3:0] tsub, ss;
  rtcawf_date_t td, a1d, a2d, tnow, t0, ts;
  rtcawf_wdg_t wd;
  rtcawf_flags_t fl, f;
  int fails = 0, num_checks = 0, cyc = 0, i;

  initial forever #5 clk = ~clk;

  rtcawf_host u_rtcawf_host (.clk(clk), .time_wr(tw), .time_wdata(td),
    .alm1_wr(a1w), .alm1_wdata(a1d), .alm2_wr(a2w), .alm2_wdata(a2d),
    .wdg_wr(ww), .wdg_wdata(wd), .flag_rd(frd), .flag_rdata(fl),
    .ens(ens), .osc_fail(of), .osc_clr(oc), .pwr_dn(pd), .halt_wr(hw),
    .halt_wdata(hd));

  rtcawf_top #(.TICK_CYCLES(TK)) u_rtcawf_top (.CLK_SYS(clk),
    .RST_N(rst_n), .TIME_WR(tw), .TIME_WDATA(td), .TIME_NOW(tnow),
    .TIME_SUB(tsub), .ALM1_WR(a1w), .ALM1_WDATA(a1d), .ALM2_WR(a2w),
    .ALM2_WDATA(a2d), .ALARM_ONE_IRQ_ENABLE(ens[2]),
    .ALARM_TWO_ENABLE(ens[1]), .ALARM_TWO_IRQ_ENABLE(ens[0]),
    .WDG_WR(ww), .WDG_WDATA(wd), .FLAG_RD(frd), .FLAG_RDATA(fl),
    .OSC_FAIL_IN(of), .OSC_FLAG_CLR(oc), .POWER_DOWN(pd), .HALT_WR(hw),
    .HALT_WDATA(hd), .CLOCK_HALT_BIT(halt),
    .INTERRUPT_LINE_ONE_N(l1_n), .INTERRUPT_LINE_TWO_N(l2_n));

  // Compare any result, four-state exact
  task automatic chk(input logic [24:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Bounded wait for an interrupt line to go low
  task automatic wait_low(input int w);
    for (i = 0; i < 300; i++) begin
      if ((w == 1 ? l1_n : l2_n) === 1'b0) break;
      @(negedge clk);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(halt, HALT_RST, "halt after reset");
    chk({l1_n, l2_n}, 2'h3, "lines after reset");
    chk(fl, FLAGS_RST, "flags after reset");
    t0 = {8'h02, 5'h03, 6'h04, 6'h05};
    u_rtcawf_host.wr_time(t0);
    repeat (40) @(negedge clk);
    chk(tnow, t0, "time moved while halted");
    chk(tsub, 4'h0, "sub moved while halted");
    u_rtcawf_host.wr_halt(1'b0);
    chk(halt, 1'b0, "halt not cleared");
    repeat (3 * TK) @(negedge clk);
    chk(tsub != 4'h0, 1'b1, "sub not advancing");
    // Alarm one, one second ahead
    u_rtcawf_host.wr_alm(1, t0 + 25'h1);
    u_rtcawf_host.en(3'h4);
    u_rtcawf_host.wr_time(t0);
    wait_low(1);
    chk(l1_n, 1'b0, "alarm one line");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h4, "alarm one flag");
    @(negedge clk);
    chk(l1_n, 1'b1, "line one after read");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h0, "flags after read");
    // Alarm two, first disabled
    u_rtcawf_host.wr_alm(1, 25'h1FFFFFF);
    u_rtcawf_host.en(3'h1);
    u_rtcawf_host.wr_alm(2, t0 + 25'h1);
    u_rtcawf_host.wr_time(t0);
    repeat (300) @(negedge clk);
    chk(l2_n, 1'b1, "alarm two while disabled");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h0, "alarm two flag disabled");
    u_rtcawf_host.en(3'h3);
    u_rtcawf_host.wr_time(t0);
    wait_low(2);
    chk(l2_n, 1'b0, "alarm two line");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h2, "alarm two flag");
    // Watchdog: resolution code 0, multiplier 3 gives 3 ticks
    u_rtcawf_host.en(3'h0);
    u_rtcawf_host.wr_wdg(7'h03);
    repeat (2 * TK - 2) @(negedge clk);
    chk(l1_n, 1'b1, "watchdog early");
    repeat (TK + 8) @(negedge clk);
    chk(l1_n, 1'b0, "watchdog late");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h8, "watchdog flag");
    repeat (3) @(negedge clk);
    chk(l1_n, 1'b0, "line one freed by read");
    u_rtcawf_host.wr_wdg(7'h00);
    repeat (2) @(negedge clk);
    chk(l1_n, 1'b1, "line one after write");
    // Resolution code 2 (16 ticks) times 8 is 128 ticks
    u_rtcawf_host.wr_wdg({2'h2, 5'h08});
    repeat (int'(RES_F2) * 8 * TK - 14) @(negedge clk);
    chk(l1_n, 1'b1, "long watchdog early");
    repeat (20) @(negedge clk);
    chk(l1_n, 1'b0, "long watchdog late");
    u_rtcawf_host.wr_wdg(7'h00);
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h8, "long watchdog flag");
    u_rtcawf_host.wr_wdg(7'h03);
    u_rtcawf_host.wr_wdg(7'h00);
    repeat (5 * TK) @(negedge clk);
    chk(l1_n, 1'b1, "watchdog not disabled");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h0, "watchdog flag disabled");
    // Oscillator flag holds through reads
    u_rtcawf_host.pulse(5);
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h1, "osc flag");
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h1, "osc flag cleared by read");
    u_rtcawf_host.pulse(6);
    u_rtcawf_host.rd_flags(f);
    chk(f, 4'h0, "osc flag not cleared");
    // Host sets the halt bit: time freezes where it stands
    u_rtcawf_host.wr_halt(1'b1);
    chk(halt, 1'b1, "halt not set by host");
    ts = tnow;
    ss = tsub;
    repeat (3 * TK) @(negedge clk);
    chk(tnow, ts, "time moved after halt write");
    chk(tsub, ss, "sub moved after halt write");
    u_rtcawf_host.wr_halt(1'b0);
    chk(halt, 1'b0, "halt not cleared again");
    u_rtcawf_host.pulse(7);
    repeat (2) @(negedge clk);
    chk(halt, 1'b1, "halt after power-down");
    // Reset in mid-run with the oscillator flag set
    u_rtcawf_host.pulse(5);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(halt, HALT_RST, "halt after second reset");
    chk(tnow, DATE_RST, "time after second reset");
    chk({l1_n, l2_n}, 2'h3, "lines after second reset");
    u_rtcawf_host.rd_flags(f);
    chk(f, FLAGS_RST, "flags after second reset");
    wrap_up();
  end
endmodule
